// ===== hdl/aao_pkg.sv
// Shared constants for the accumulator ALU operation block.
// Assumes an 8-bit datapath driven by an instruction decoder on one clock.
package aao_pkg;
  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 7;
  localparam int PORT_CNT    = 3;
  // Operation codes presented by the decoder.
  typedef enum logic [2:0] {
    AAO_OP_NONE,
    AAO_OP_SUB_BORROW,
    AAO_OP_SWAP,
    AAO_OP_LOAD_DIR,
    AAO_OP_XOR_LIT,
    AAO_OP_XOR_FILE
  } aao_op_t;
  // Direction selector operands.
  localparam logic [ADDR_W-1:0] DIR_SEL_A = 7'h05;
  localparam logic [ADDR_W-1:0] DIR_SEL_B = 7'h06;
  localparam logic [ADDR_W-1:0] DIR_SEL_C = 7'h07;
  // Reset values, destination selects and nibble bounds.
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DIR_RESET = 8'hFF;
  localparam logic              FLAG_RESET = 1'b0;
  localparam logic              DEST_ACC  = 1'b0;
  localparam logic              DEST_FILE = 1'b1;
  localparam int NIB_LO_MSB = 3;
  localparam int NIB_HI_LSB = 4;
endpackage

// ===== hdl/aao_dir_regs.sv
// Three port direction registers loaded from the accumulator.
// Assumes the load strobe comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module aao_dir_regs #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys_i,  // System clock.
  input  wire logic             reset_i,    // Synchronous reset.
  input  wire logic [2:0]       load_i,     // One-hot load per port.
  input  wire logic [WIDTH-1:0] data_i,     // Value to load.
  output logic      [WIDTH-1:0] dir_a_o,    // Port A direction.
  output logic      [WIDTH-1:0] dir_b_o,    // Port B direction.
  output logic      [WIDTH-1:0] dir_c_o     // Port C direction.
);
  logic [WIDTH-1:0] dir_reg [3];

  // Each register reloads only on its own strobe; reset makes pins inputs.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_dir
      always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
          dir_reg[g] <= WIDTH'(aao_pkg::DIR_RESET);
        end else if (load_i[g]) begin
          dir_reg[g] <= data_i;
        end
      end
    end
  endgenerate

  assign dir_a_o = dir_reg[0];
  assign dir_b_o = dir_reg[1];
  assign dir_c_o = dir_reg[2];
endmodule // aao_dir_regs
`default_nettype wire

// ===== hdl/aao_core.sv
// Accumulator ALU operations: subtract with borrow, nibble swap,
// port direction load, and XOR with literal or file register.
// Assumes the decoder holds one operation per cycle with its operand and
// that the register file supplies the addressed byte in that same cycle.
//
// Contract
// - Subtract with borrow: file minus accumulator minus inverted carry.
// - Subtract-with-borrow updates carry, half carry and zero only.
// - Destination select 0 writes accumulator, 1 writes the file register.
// - Nibble swap exchanges low and high nibbles; flags untouched.
// - Direction load copies accumulator to port A, B or C by operand 5-7.
// - XOR literal: accumulator XOR literal into accumulator; zero only.
// - XOR file XORs with file byte, routed by select; zero only.
`timescale 1ns/1ps
`default_nettype none
module aao_core #(
  parameter int DW = aao_pkg::DATA_W,
  parameter int AW = aao_pkg::ADDR_W
) (
  input  wire logic          clk_sys_i,      // System clock, 250 MHz.
  input  wire logic          reset_i,        // Synchronous reset.
  input  wire logic          op_valid_i,     // Operation strobe.
  input  wire logic [2:0]    op_i,           // Operation code.
  input  wire logic [AW-1:0] file_addr_i,    // File address or selector.
  input  wire logic          dest_i,         // Destination select.
  input  wire logic [DW-1:0] literal_i,      // Immediate operand.
  input  wire logic [DW-1:0] file_rdata_i,   // Addressed file byte.
  output logic      [DW-1:0] acc_o,          // Working register.
  output logic               carry_o,        // Carry flag.
  output logic               half_carry_flag_o, // Digit carry flag.
  output logic               zero_o,         // Zero flag.
  output logic               file_we_o,      // File write pulse.
  output logic      [AW-1:0] file_waddr_o,   // File write address.
  output logic      [DW-1:0] file_wdata_o,   // File write data.
  output logic      [DW-1:0] port_a_direction_o, // Port A direction.
  output logic      [DW-1:0] port_b_direction_o, // Port B direction.
  output logic      [DW-1:0] port_c_direction_o  // Port C direction.
);
  typedef struct packed {
    logic [DW-1:0] acc;
    logic          c;
    logic          dc;
    logic          z;
    logic          we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [2:0]    dir_load;
  } aao_state_t;

  aao_state_t st_reg;
  aao_state_t st_next;
  aao_pkg::aao_op_t op;

  // Every assertion below runs on the system clock and rests in reset.
  default clocking cb_sys @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  assign op = aao_pkg::aao_op_t'(op_i);

  // Route a result to accumulator or file depending on the select.
  function automatic aao_state_t route(input aao_state_t s,
                                       input logic [DW-1:0] res,
                                       input logic d,
                                       input logic [AW-1:0] a);
    aao_state_t r;
    r = s;
    if (d == aao_pkg::DEST_FILE) begin
      r.we    = 1'b1;
      r.waddr = a;
      r.wdata = res;
    end else begin
      r.acc = res;
    end
    return r;
  endfunction

  // Next-state logic; write and load strobes fall back to zero each cycle.
  always_comb begin
    logic [DW:0]   diff;
    logic [4:0]    ldiff;
    logic [DW-1:0] res;
    diff = '0;
    ldiff = '0;
    res = '0;
    st_next = st_reg;
    st_next.we = 1'b0;
    st_next.dir_load = 3'h0;
    if (op_valid_i) begin
      unique case (op)
        aao_pkg::AAO_OP_SUB_BORROW: begin
          // Carry set means no borrow, so borrow in is the inverted carry.
          diff = {1'b0, file_rdata_i} - {1'b0, st_reg.acc}
                 - {{DW{1'b0}}, ~st_reg.c};
          ldiff = {1'b0, file_rdata_i[3:0]} - {1'b0, st_reg.acc[3:0]}
                  - {4'h0, ~st_reg.c};
          res = diff[DW-1:0];
          st_next = route(st_next, res, dest_i, file_addr_i);
          st_next.c  = ~diff[DW];
          st_next.dc = ~ldiff[4];
          st_next.z  = (res == '0);
        end
        aao_pkg::AAO_OP_SWAP: begin
          res = {file_rdata_i[aao_pkg::NIB_LO_MSB:0],
                 file_rdata_i[DW-1:aao_pkg::NIB_HI_LSB]};
          st_next = route(st_next, res, dest_i, file_addr_i);
        end
        aao_pkg::AAO_OP_LOAD_DIR: begin
          // Operands outside 5..7 load nothing.
          st_next.dir_load = {file_addr_i == aao_pkg::DIR_SEL_C,
                              file_addr_i == aao_pkg::DIR_SEL_B,
                              file_addr_i == aao_pkg::DIR_SEL_A};
        end
        aao_pkg::AAO_OP_XOR_LIT: begin
          res = st_reg.acc ^ literal_i;
          st_next.acc = res;
          st_next.z = (res == '0);
        end
        aao_pkg::AAO_OP_XOR_FILE: begin
          res = st_reg.acc ^ file_rdata_i;
          st_next = route(st_next, res, dest_i, file_addr_i);
          st_next.z = (res == '0);
        end
        default: begin
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_reg.acc      <= aao_pkg::ACC_RESET;
      st_reg.c        <= aao_pkg::FLAG_RESET;
      st_reg.dc       <= aao_pkg::FLAG_RESET;
      st_reg.z        <= aao_pkg::FLAG_RESET;
      st_reg.we       <= 1'b0;
      st_reg.waddr    <= '0;
      st_reg.wdata    <= '0;
      st_reg.dir_load <= 3'h0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Direction registers load at the edge after the strobe. The load itself
  // leaves the accumulator alone, so it still holds the value it saw.

  aao_dir_regs #(.WIDTH(DW)) u_dir (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .load_i    (st_reg.dir_load),
    .data_i    (st_reg.acc),
    .dir_a_o   (port_a_direction_o),
    .dir_b_o   (port_b_direction_o),
    .dir_c_o   (port_c_direction_o)
  );

  assign acc_o             = st_reg.acc;
  assign carry_o           = st_reg.c;
  assign half_carry_flag_o = st_reg.dc;
  assign zero_o            = st_reg.z;
  assign file_we_o         = st_reg.we;
  assign file_waddr_o      = st_reg.waddr;
  assign file_wdata_o      = st_reg.wdata;

  // Assertions; each looks one edge after the operation is taken, where
  // the registered result first stands; a_dir_a_load also looks one edge later.
  a_xor_lit_result: assert property (
    op_valid_i && op == aao_pkg::AAO_OP_XOR_LIT |=>
      acc_o == ($past(acc_o) ^ $past(literal_i)) && !file_we_o)
    else $error("XOR literal result wrong");

  a_zero_flag_rule: assert property (
    op_valid_i && (op == aao_pkg::AAO_OP_XOR_LIT) |=>
      zero_o == (acc_o == '0))
    else $error("zero flag mismatch");

  a_swap_no_flags: assert property (
    op_valid_i && op == aao_pkg::AAO_OP_SWAP |=>
      $stable({carry_o, half_carry_flag_o, zero_o}))
    else $error("swap changed flags");

  a_swap_to_file: assert property (
    op_valid_i && op == aao_pkg::AAO_OP_SWAP && dest_i |=> file_we_o &&
      file_wdata_o == {$past(file_rdata_i[3:0]), $past(file_rdata_i[7:4])})
    else $error("swap file write wrong");

  a_swap_to_acc: assert property (
    op_valid_i && op == aao_pkg::AAO_OP_SWAP && !dest_i |=> !file_we_o &&
      acc_o == {$past(file_rdata_i[3:0]), $past(file_rdata_i[7:4])})
    else $error("swap accumulator result wrong");

  a_dest_acc_only: assert property (
    op_valid_i && op == aao_pkg::AAO_OP_XOR_FILE && !dest_i |=>
      !file_we_o && acc_o == ($past(acc_o) ^ $past(file_rdata_i)))
    else $error("xor file to accumulator wrong");

  a_xor_file_write: assert property (
    op_valid_i && op == aao_pkg::AAO_OP_XOR_FILE && dest_i |=>
      file_we_o && file_waddr_o == $past(file_addr_i) && $stable(acc_o) &&
      file_wdata_o == ($past(acc_o) ^ $past(file_rdata_i)))
    else $error("xor file write-back wrong");

  a_sub_borrow_res: assert property (
    op_valid_i && op == aao_pkg::AAO_OP_SUB_BORROW && !dest_i |=>
      acc_o == DW'($past(file_rdata_i) - $past(acc_o)
        - {7'h0, !$past(carry_o)}))
    else $error("subtract with borrow wrong");

  a_sub_carry_out: assert property (
    op_valid_i && op == aao_pkg::AAO_OP_SUB_BORROW |=>
      carry_o == ({1'b0, $past(file_rdata_i)} >= ({1'b0, $past(acc_o)}
        + {8'h0, !$past(carry_o)})))
    else $error("subtract carry wrong");

  a_sub_half_carry: assert property (
    op_valid_i && op == aao_pkg::AAO_OP_SUB_BORROW |=>
      half_carry_flag_o == ({1'b0, $past(file_rdata_i[3:0])}
        >= ({1'b0, $past(acc_o[3:0])} + {4'h0, !$past(carry_o)})))
    else $error("subtract half carry wrong");

  // A direction load has two steps: flags hold while the strobe is
  // registered, then the port shows the accumulator that the load saw.
  // A following operation may change the flags, so only step one looks.
  sequence s_dir_a_req;
    op_valid_i && op == aao_pkg::AAO_OP_LOAD_DIR &&
      file_addr_i == aao_pkg::DIR_SEL_A;
  endsequence
  sequence s_dir_flags_hold;
    $stable({carry_o, half_carry_flag_o, zero_o}) && !file_we_o;
  endsequence
  a_dir_a_load: assert property (
    s_dir_a_req |=> s_dir_flags_hold
      ##1 port_a_direction_o == $past(acc_o, 2))
    else $error("port A direction load wrong");

  a_load_no_write: assert property (
    op_valid_i && op == aao_pkg::AAO_OP_LOAD_DIR |=>
      !file_we_o && $stable(acc_o))
    else $error("direction load touched a result");
endmodule // aao_core
`default_nettype wire

// ===== tb/aao_file_model.sv
// Register file partner: 128 bytes, read in the cycle of the operation.
// Assumes write-backs arrive as a one-cycle strobe on the core clock.
`timescale 1ns/1ps
`default_nettype none
module aao_file_model (
  input  wire logic       clk_sys_i,  // System clock.
  input  wire logic       op_valid_i, // A read is wanted while high.
  input  wire logic [6:0] addr_i,     // Read address.
  input  wire logic       we_i,       // Write strobe.
  input  wire logic [6:0] waddr_i,    // Write address.
  input  wire logic [7:0] wdata_i,    // Write data.
  output logic      [7:0] rdata_o     // Addressed byte.
);
  logic [7:0] mem [128];
  // Same fill as the bench shadow, so both start from equal contents.
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i * 37 + 91);
    end
  end
  // Outside a request the byte is inverted, so a stale read cannot pass.
  assign rdata_o = op_valid_i ? mem[addr_i] : ~mem[addr_i];
  // Write-backs land at the edge that sees the strobe.
  always @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end
endmodule // aao_file_model
`default_nettype wire

// ===== tb/aao_core_bench.sv
// Bench for the accumulator ALU block with a shadow of acc, flags, memory.
// Assumes aao_file_model answers reads in the same cycle as the operation.
`timescale 1ns/1ps
`default_nettype none
module aao_core_bench;
  logic       clk_sys_i, reset_i, op_valid_i, dest_i, c, dc, z, we;
  logic       carry_o, half_carry_flag_o, zero_o;
  logic [2:0] op_i;
  logic [6:0] file_addr_i, waddr;
  logic [7:0] literal_i, rdata, acc_o, wdata, acc, k, mem [128], dirs [3];
  logic [7:0] dir_a, dir_b, dir_c;
  int         miscompares, total_checks;
  aao_core u_aao_core (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .op_valid_i(op_valid_i), .op_i(op_i), .file_addr_i(file_addr_i),
    .dest_i(dest_i), .literal_i(literal_i), .file_rdata_i(rdata),
    .acc_o(acc_o), .carry_o(carry_o), .half_carry_flag_o(half_carry_flag_o),
    .zero_o(zero_o), .file_we_o(we), .file_waddr_o(waddr),
    .file_wdata_o(wdata), .port_a_direction_o(dir_a),
    .port_b_direction_o(dir_b), .port_c_direction_o(dir_c));
  aao_file_model u_aao_file_model (.clk_sys_i(clk_sys_i),
    .op_valid_i(op_valid_i), .addr_i(file_addr_i), .we_i(we),
    .waddr_i(waddr), .wdata_i(wdata), .rdata_o(rdata));
  // Byte and bit comparisons; every mismatch is counted at once.
  task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(string n, logic e, logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask
  task automatic summarize();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One operation: present for one edge, predict, then check both answers.
  task automatic run(logic [2:0] o, logic [6:0] a, logic d, logic [7:0] l);
    logic [7:0] f, r;
    logic [8:0] w;
    logic [4:0] h;
    f = mem[a];
    r = acc;
    @(posedge clk_sys_i);
    op_valid_i <= 1'b1;
    op_i <= o;
    file_addr_i <= a;
    dest_i <= d;
    literal_i <= l;
    @(posedge clk_sys_i);
    op_valid_i <= 1'b0;
    case (o)
      3'h1: begin
        w = {1'b0, f} - {1'b0, acc} - {8'h00, ~c};
        h = {1'b0, f[3:0]} - {1'b0, acc[3:0]} - {4'h0, ~c};
        r = w[7:0];
        c = ~w[8];
        dc = ~h[4];
        z = (r == 8'h00);
      end
      3'h2: r = {f[3:0], f[7:4]};
      3'h4: r = acc ^ l;
      3'h5: r = acc ^ f;
      default: ;
    endcase
    if (o inside {3'h4, 3'h5}) z = (r == 8'h00);
    #1;
    if (o inside {3'h1, 3'h2, 3'h5} && d) begin
      chk1("file_we", 1'b1, we);
      chk8("waddr", {1'b0, a}, {1'b0, waddr});
      chk8("wdata", r, wdata);
      mem[a] = r;
    end else begin
      chk1("file_we", 1'b0, we);
      if (o inside {3'h1, 3'h2, 3'h4, 3'h5}) acc = r;
    end
    if (o == 3'h3 && a inside {7'h05, 7'h06, 7'h07}) dirs[a - 7'h05] = acc;
    @(posedge clk_sys_i);
    #1;
    chk1("file_we_drop", 1'b0, we);
    chk8("acc", acc, acc_o);
    chk1("carry", c, carry_o);
    chk1("half_carry", dc, half_carry_flag_o);
    chk1("zero", z, zero_o);
    chk8("dir_a", dirs[0], dir_a);
    chk8("dir_b", dirs[1], dir_b);
    chk8("dir_c", dirs[2], dir_c);
  endtask
  // Free-running 250 MHz clock.
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    #20000;
    miscompares++;
    summarize();
  end
  // Reset, then each operation with boundary operands and refusals.
  initial begin
    {reset_i, op_valid_i, op_i, file_addr_i, dest_i, literal_i} = '0;
    reset_i = 1'b1;
    {miscompares, total_checks} = '0;
    {acc, c, dc, z} = '0;
    for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 91);
    for (int i = 0; i < 3; i++) dirs[i] = 8'hFF;
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    run(3'h0, 7'h00, 1'b1, 8'h00);
    run(3'h4, 7'h00, 1'b0, 8'h00);
    run(3'h4, 7'h00, 1'b1, 8'hA5);
    for (int i = 0; i < 8; i++) run(3'h1, 7'(i * 18), 1'(i), 8'h00);
    run(3'h1, 7'h7F, 1'b1, 8'h00);
    run(3'h2, 7'h10, 1'b0, 8'h00);
    run(3'h2, 7'h11, 1'b1, 8'h00);
    k = mem[7'h22];
    run(3'h5, 7'h22, 1'b1, 8'h00);
    run(3'h4, 7'h00, 1'b0, k);
    run(3'h5, 7'h22, 1'b0, 8'h00);
    for (int i = 4; i < 8; i++) begin
      run(3'h4, 7'h00, 1'b0, 8'(i * 17));
      run(3'h3, 7'(i), 1'b0, 8'h00);
    end
    run(3'h3, 7'h7F, 1'b0, 8'h00);
    run(3'h6, 7'h05, 1'b1, 8'hFF);
    // Back to back: a port A load, then an XOR that sees the same value.
    @(posedge clk_sys_i);
    op_valid_i <= 1'b1;
    op_i <= 3'h3;
    file_addr_i <= 7'h05;
    dest_i <= 1'b0;
    @(posedge clk_sys_i);
    op_i <= 3'h4;
    literal_i <= 8'h5A;
    @(posedge clk_sys_i);
    op_valid_i <= 1'b0;
    dirs[0] = acc;
    acc = acc ^ 8'h5A;
    z = (acc == 8'h00);
    @(posedge clk_sys_i);
    #1;
    chk8("b2b_dir_a", dirs[0], dir_a);
    chk8("b2b_acc", acc, acc_o);
    chk1("b2b_zero", z, zero_o);
    chk1("b2b_file_we", 1'b0, we);
    summarize();
  end
endmodule // aao_core_bench
`default_nettype wire
